// file: cmtf_bus_node.sv
/*
  far side model: the other nodes of the shared CAN bus, seen as bus bit
  ticks with their level and as received frames with identifier start.
  assumes the mclk and rstn of the block under test.
*/
`timescale 1ns/1ps
module cmtf_bus_node (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic bits_go,
  input wire logic [15:0] bits_n,
  input wire logic [15:0] dom_at,
  input wire logic frame_go,
  input wire logic [cmtf_pkg::KEY_W-1:0] frame_key,
  output logic bit_tick,
  output logic bus_recessive,
  output logic id_start,
  output logic rx_frame_ok,
  output logic [cmtf_pkg::KEY_W-1:0] rx_key,
  output logic busy
);
  import cmtf_pkg::*;
  logic [15:0] left_q;
  logic [15:0] idx_q;
  logic [1:0] div_q;
  logic [2:0] fr_q;
  logic [KEY_W-1:0] key_q;

  assign busy = (left_q != 16'h0000) || (fr_q != 3'h0) || rx_frame_ok;

  // ***********************************************************
  // bus bits
  // ***********************************************************
  // one bit every four clocks; the idle bus rests recessive
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      left_q <= 16'h0000;
      idx_q <= 16'h0000;
      div_q <= 2'h0;
      bit_tick <= 1'b0;
      bus_recessive <= 1'b1;
    end
    else if (bits_go)
    begin
      left_q <= bits_n;
      idx_q <= 16'h0000;
      div_q <= 2'h0;
      bit_tick <= 1'b0;
    end
    else if (left_q != 16'h0000)
    begin
      div_q <= div_q + 2'h1;
      bit_tick <= (div_q == 2'h3);
      if (div_q == 2'h2)
        bus_recessive <= (idx_q != dom_at);
      if (div_q == 2'h3)
      begin
        left_q <= left_q - 16'h0001;
        idx_q <= idx_q + 16'h0001;
      end
    end
    else
    begin
      bit_tick <= 1'b0;
      bus_recessive <= 1'b1;
    end
  end

  // ***********************************************************
  // frames
  // ***********************************************************
  // the key is only valid with the ok pulse; otherwise it keeps toggling
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      fr_q <= 3'h0;
      id_start <= 1'b0;
      rx_frame_ok <= 1'b0;
      rx_key <= '0;
      key_q <= '0;
    end
    else if (frame_go)
    begin
      fr_q <= 3'h4;
      id_start <= 1'b1;
      key_q <= frame_key;
      rx_key <= ~rx_key;
      rx_frame_ok <= 1'b0;
    end
    else
    begin
      id_start <= 1'b0;
      rx_frame_ok <= (fr_q == 3'h1);
      rx_key <= (fr_q == 3'h1) ? key_q : ~rx_key;
      if (fr_q != 3'h0)
        fr_q <= fr_q - 3'h1;
    end
  end
endmodule : cmtf_bus_node

// file: cmtf_core.sv
/*
  acceptance masking, bit timing, error counters with fault confinement,
  receive locks and frame time stamps of a CAN controller.
  assumes the protocol engine reports bit ticks, errors and frame events
  as one-cycle pulses synchronous to mclk.
*/
// Operation
// - buffers 0 to 13 share one acceptance mask.
// - buffers 14 and 15 each have a mask of their own.
// - mask bit 0 ignores the identifier bit, 1 requires equality.
// - frame held for a locked buffer goes there on release, mask regardless.
// - prescaler and two control bytes hold all bit timing fields.
// - quantum clock is system clock divided by prescaler plus one.
// - processing time is three quanta at one clock per quantum, else two.
// - phase segment two of two makes transmission start one quantum late.
// - under ten clocks per bit an early start of frame may be missed.
// - counters step up by eight or one, down by one, never below zero.
// - counters reset to zero; writes only in test, freeze or halt.
// - either counter at 128 or more makes the state error passive.
// - both counters at 127 or less return passive to active.
// - transmit counter passing 255 enters bus off and clears it.
// - bus off counts 128 runs of 11 recessive bits, then goes active.
// - acknowledge errors never move passive into bus off.
// - receive counter stops above 127, reloads 119..127 on good reception.
// - flags follow the state; passive delays; bus off drives nothing.
// - timer sampled at identifier start, stored with frame or transmission.
// - optional timer reset on reception into buffer 0.
// - lowest numbered matching active buffer takes the frame.
// - control word read locks a buffer; timer read releases all.
`timescale 1ns/1ps
module cmtf_core (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic soft_reset,
  input wire logic cfg_write_ok,
  input wire logic [2:0] timing_we,
  input wire logic [7:0] timing_wdata,
  input wire logic [cmtf_pkg::KEY_W-1:0] mask_shared,
  input wire logic [cmtf_pkg::KEY_W-1:0] mask_own_a,
  input wire logic [cmtf_pkg::KEY_W-1:0] mask_own_b,
  input wire logic [cmtf_pkg::NUM_BUF*cmtf_pkg::KEY_W-1:0] buf_key,
  input wire logic [cmtf_pkg::NUM_BUF-1:0] buf_rx_active,
  input wire logic rx_frame_ok,
  input wire logic [cmtf_pkg::KEY_W-1:0] rx_key,
  input wire logic cs_read,
  input wire logic [3:0] cs_read_idx,
  input wire logic timer_read,
  input wire logic timer_sync_en,
  input wire logic id_start,
  input wire logic tx_frame_ok,
  input wire logic tx_err,
  input wire logic ack_err,
  input wire logic rx_err_one,
  input wire logic rx_err_eight,
  input wire logic bit_tick,
  input wire logic bus_recessive,
  input wire logic [1:0] cnt_we,
  input wire logic [7:0] cnt_wdata,
  output cmtf_pkg::cmtf_fcs_t fault_confinement_state,
  output logic [7:0] tx_err_cnt_q,
  output logic [7:0] rx_err_cnt_q,
  output logic busoff_evt_q,
  output logic err_flag_passive_q,
  output logic tx_delay_q,
  output logic bus_drive_en_q,
  output logic [7:0] quantum_prescaler_divider,
  output logic [7:0] bit_timing_control_one,
  output logic [7:0] bit_timing_control_two,
  output logic quantum_tick_q,
  output logic [1:0] info_processing_time,
  output logic tx_late_q,
  output logic cfg_phase_segment_two_field_bad_q,
  output logic cfg_bit_short_q,
  output logic sof_risk_q,
  output logic dlv_q,
  output logic [3:0] dlv_idx_q,
  output logic [15:0] dlv_stamp_q,
  output logic lock_valid_q,
  output logic [3:0] lock_idx_q,
  output logic [15:0] timer_q,
  output logic [15:0] tx_stamp_q,
  output logic tx_stamp_vld_q
);
  import cmtf_pkg::*;

  // ***********************************************************
  // bit timing
  // ***********************************************************
  logic [7:0] q_cnt_q;
  logic [2:0] prop_seg;
  logic [2:0] phase_one;
  logic [2:0] phase_two;
  logic [8:0] clk_per_tq;
  logic [4:0] tq_per_bit;
  logic [15:0] clk_per_bit;

  assign prop_seg = bit_timing_control_one[PROP_LSB +: 3];
  assign phase_one = bit_timing_control_two[PHASE_SEGMENT_ONE_FIELD_LSB +: 3];
  assign phase_two = bit_timing_control_two[PHASE_SEGMENT_TWO_FIELD_LSB +: 3];
  assign clk_per_tq = {1'b0, quantum_prescaler_divider} + 9'h001;
  // sync quantum plus each segment field plus one
  assign tq_per_bit = 5'h04 + {2'b00, prop_seg} + {2'b00, phase_one}
    + {2'b00, phase_two};
  // widen before the product; nine bits would wrap at large dividers
  assign clk_per_bit = 16'(clk_per_tq) * 16'(tq_per_bit);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      quantum_prescaler_divider <= TIMING_RST;
      bit_timing_control_one <= TIMING_RST;
      bit_timing_control_two <= TIMING_RST;
    end
    else if (ce && cfg_write_ok)
    begin
      if (timing_we[0]) quantum_prescaler_divider <= timing_wdata;
      if (timing_we[1]) bit_timing_control_one <= timing_wdata;
      if (timing_we[2]) bit_timing_control_two <= timing_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      q_cnt_q <= TIMING_RST;
      quantum_tick_q <= 1'b0;
    end
    else if (ce)
    begin
      quantum_tick_q <= (q_cnt_q >= quantum_prescaler_divider);
      if (q_cnt_q >= quantum_prescaler_divider) q_cnt_q <= TIMING_RST;
      else q_cnt_q <= q_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      info_processing_time <= IPT_FAST;
      tx_late_q <= 1'b0;
      cfg_phase_segment_two_field_bad_q <= 1'b0;
      cfg_bit_short_q <= 1'b0;
      sof_risk_q <= 1'b0;
    end
    else if (ce)
    begin
      info_processing_time <= (quantum_prescaler_divider == TIMING_RST) ?
        IPT_FAST : IPT_SLOW;
      tx_late_q <= (phase_two == PHASE_SEGMENT_TWO_FIELD_LATE);
      cfg_phase_segment_two_field_bad_q <= (quantum_prescaler_divider == TIMING_RST) &&
        (phase_two == 3'h0);
      cfg_bit_short_q <= (clk_per_bit < MIN_BIT_CLKS);
      sof_risk_q <= (clk_per_bit < SOF_SAFE_CLKS);
    end
  end

  // ***********************************************************
  // acceptance and delivery
  // ***********************************************************
  logic hit;
  logic [3:0] hit_idx;
  logic [KEY_W-1:0] msk;
  logic pend_q;
  logic [3:0] pend_idx_q;
  logic [15:0] pend_stamp_q;
  logic [15:0] stamp_q;
  logic fire;
  logic [3:0] fire_idx;
  logic [15:0] fire_stamp;
  logic now_locked;
  logic pend_locked;

  always_comb
  begin
    hit = 1'b0;
    hit_idx = 4'h0;
    msk = mask_shared;
    for (int i = NUM_BUF - 1; i >= 0; i--)
    begin
      msk = mask_shared;
      if (i == BUF_OWN_A) msk = mask_own_a;
      if (i == BUF_OWN_B) msk = mask_own_b;
      if (buf_rx_active[i] &&
          cmtf_match(rx_key, buf_key[i*KEY_W +: KEY_W], msk))
      begin
        hit = 1'b1;
        hit_idx = 4'(i);
      end
    end
  end

  assign now_locked = lock_valid_q && (lock_idx_q == hit_idx);
  assign pend_locked = lock_valid_q && (lock_idx_q == pend_idx_q);

  always_comb
  begin
    fire = 1'b0;
    fire_idx = pend_idx_q;
    fire_stamp = pend_stamp_q;
    if (pend_q && !pend_locked)
      fire = 1'b1;
    else if (rx_frame_ok && hit && !now_locked)
    begin
      fire = 1'b1;
      fire_idx = hit_idx;
      fire_stamp = stamp_q;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_q <= 1'b0;
      pend_idx_q <= 4'h0;
      pend_stamp_q <= TIMER_RST;
    end
    else if (ce)
    begin
      if (rx_frame_ok && hit && now_locked)
      begin
        pend_q <= 1'b1;
        pend_idx_q <= hit_idx;
        pend_stamp_q <= stamp_q;
      end
      else if (pend_q && !pend_locked)
        pend_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      dlv_q <= 1'b0;
      dlv_idx_q <= 4'h0;
      dlv_stamp_q <= TIMER_RST;
    end
    else if (ce)
    begin
      dlv_q <= fire;
      if (fire)
      begin
        dlv_idx_q <= fire_idx;
        dlv_stamp_q <= fire_stamp;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      lock_valid_q <= 1'b0;
      lock_idx_q <= 4'h0;
    end
    else if (ce)
    begin
      if (timer_read)
        lock_valid_q <= 1'b0;
      // a buffer being filled is busy and refuses the lock
      else if (cs_read && !(fire && fire_idx == cs_read_idx))
      begin
        lock_valid_q <= 1'b1;
        lock_idx_q <= cs_read_idx;
      end
    end
  end

  // ***********************************************************
  // timer and stamps
  // ***********************************************************
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_q <= TIMER_RST;
      stamp_q <= TIMER_RST;
      tx_stamp_q <= TIMER_RST;
      tx_stamp_vld_q <= 1'b0;
    end
    else if (ce)
    begin
      if (timer_sync_en && fire && fire_idx == 4'h0) timer_q <= TIMER_RST;
      else timer_q <= timer_q + 16'h0001;
      if (id_start) stamp_q <= timer_q;
      tx_stamp_vld_q <= tx_frame_ok;
      if (tx_frame_ok) tx_stamp_q <= stamp_q;
    end
  end

  // ***********************************************************
  // error counters and fault confinement
  // ***********************************************************
  cmtf_fcs_t fcs_d;
  logic [7:0] tec_d;
  logic [7:0] rec_d;
  logic [3:0] run_q;
  logic [3:0] run_d;
  logic boff_d;

  always_comb
  begin
    tec_d = tx_err_cnt_q;
    rec_d = rx_err_cnt_q;
    fcs_d = fault_confinement_state;
    run_d = run_q;
    boff_d = 1'b0;
    if (fault_confinement_state == FCS_BUSOFF)
    begin
      if (bit_tick)
      begin
        if (!bus_recessive) run_d = 4'h0;
        else if (run_q == RECESSIVE_RUN - 4'h1)
        begin
          run_d = 4'h0;
          tec_d = tx_err_cnt_q + 8'h01;
        end
        else run_d = run_q + 4'h1;
      end
      if (tec_d == PASSIVE_LIM)
      begin
        fcs_d = FCS_ACTIVE;
        tec_d = CNT_RST;
        rec_d = CNT_RST;
      end
    end
    else
    begin
      if (tx_err)
      begin
        if (tx_err_cnt_q > 8'hff - ERR_STEP)
        begin
          if (ack_err && fault_confinement_state == FCS_PASSIVE)
            tec_d = tx_err_cnt_q;
          else
          begin
            tec_d = CNT_RST;
            fcs_d = FCS_BUSOFF;
            boff_d = 1'b1;
          end
        end
        else tec_d = tx_err_cnt_q + ERR_STEP;
      end
      else if (tx_frame_ok && tx_err_cnt_q != CNT_RST)
        tec_d = tx_err_cnt_q - 8'h01;
      if (rx_err_one || rx_err_eight)
      begin
        if (rx_err_cnt_q < PASSIVE_LIM)
          rec_d = rx_err_cnt_q + (rx_err_eight ? ERR_STEP : 8'h01);
      end
      else if (rx_frame_ok)
      begin
        if (rx_err_cnt_q >= PASSIVE_LIM) rec_d = RX_RELOAD;
        else if (rx_err_cnt_q != CNT_RST) rec_d = rx_err_cnt_q - 8'h01;
      end
      // test-mode writes
      // state follows written counters, never a stale value
      if (cfg_write_ok && cnt_we[0]) tec_d = cnt_wdata;
      if (cfg_write_ok && cnt_we[1]) rec_d = cnt_wdata;
      if (!boff_d)
        fcs_d = (tec_d >= PASSIVE_LIM || rec_d >= PASSIVE_LIM) ?
          FCS_PASSIVE : FCS_ACTIVE;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_err_cnt_q <= CNT_RST;
      rx_err_cnt_q <= CNT_RST;
      fault_confinement_state <= FCS_ACTIVE;
      run_q <= 4'h0;
      busoff_evt_q <= 1'b0;
    end
    else if (ce)
    begin
      busoff_evt_q <= boff_d && !soft_reset;
      run_q <= soft_reset ? 4'h0 : run_d;
      if (soft_reset)
      begin
        tx_err_cnt_q <= CNT_RST;
        rx_err_cnt_q <= CNT_RST;
        fault_confinement_state <= FCS_ACTIVE;
      end
      else
      begin
        fault_confinement_state <= fcs_d;
        tx_err_cnt_q <= (cfg_write_ok && cnt_we[0]) ? cnt_wdata : tec_d;
        rx_err_cnt_q <= (cfg_write_ok && cnt_we[1]) ? cnt_wdata : rec_d;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      err_flag_passive_q <= 1'b0;
      tx_delay_q <= 1'b0;
      bus_drive_en_q <= 1'b1;
    end
    else if (ce)
    begin
      err_flag_passive_q <= (fault_confinement_state == FCS_PASSIVE);
      tx_delay_q <= (fault_confinement_state == FCS_PASSIVE);
      bus_drive_en_q <= (fault_confinement_state != FCS_BUSOFF);
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  logic clean;
  assign clean = ce && !soft_reset && !cfg_write_ok;

  sequence s_boff_enter;
    clean && fault_confinement_state != FCS_BUSOFF && tx_err &&
      !ack_err && tx_err_cnt_q > 8'hf7;
  endsequence

  AST_BUSOFF_ENTRY: assert property (s_boff_enter |=>
    fault_confinement_state == FCS_BUSOFF && tx_err_cnt_q == 8'h00 &&
    busoff_evt_q) else $error("bus off entry wrong");
  AST_PASSIVE_LIMIT: assert property (
    fault_confinement_state != FCS_BUSOFF &&
    (tx_err_cnt_q >= 8'h80 || rx_err_cnt_q >= 8'h80) |->
    fault_confinement_state == FCS_PASSIVE) else $error("not passive");
  AST_ACTIVE_RETURN: assert property (
    fault_confinement_state == FCS_PASSIVE |->
    tx_err_cnt_q >= 8'h80 || rx_err_cnt_q >= 8'h80)
    else $error("passive without cause");
  AST_ACK_NO_BUSOFF: assert property (clean && ack_err && tx_err &&
    fault_confinement_state == FCS_PASSIVE |=>
    fault_confinement_state != FCS_BUSOFF) else $error("ack bus off");
  AST_TEC_FLOOR: assert property (clean && tx_err_cnt_q == 8'h00 &&
    fault_confinement_state != FCS_BUSOFF && !tx_err |=>
    tx_err_cnt_q == 8'h00) else $error("counter went below zero");
  AST_REC_RELOAD: assert property (clean && rx_frame_ok &&
    !rx_err_one && !rx_err_eight && rx_err_cnt_q >= 8'h80 &&
    fault_confinement_state != FCS_BUSOFF |=>
    rx_err_cnt_q >= 8'd119 && rx_err_cnt_q <= 8'd127)
    else $error("receive counter reload out of range");
  AST_RECOVERY: assert property (clean && bit_tick &&
    bus_recessive && run_q == 4'ha && tx_err_cnt_q == 8'h7f &&
    fault_confinement_state == FCS_BUSOFF |=>
    fault_confinement_state == FCS_ACTIVE && tx_err_cnt_q == 8'h00 &&
    rx_err_cnt_q == 8'h00) else $error("recovery missed");
  AST_QUIET_BUSOFF: assert property (ce &&
    fault_confinement_state == FCS_BUSOFF |=> !bus_drive_en_q)
    else $error("drives bus in bus off");
  AST_IPT: assert property (ce ##1 ce |-> info_processing_time ==
    ($past(quantum_prescaler_divider) == 8'h00 ? 2'h3 : 2'h2))
    else $error("processing time wrong");
  AST_STAMP: assert property (ce && id_start |=>
    stamp_q == $past(timer_q)) else $error("stamp not sampled");
  AST_NO_LOCKED_FILL: assert property (dlv_q |->
    $past(pend_q) || !$past(now_locked)) else $error("locked fill");

endmodule : cmtf_core

// file: cmtf_pkg.sv
/*
  constants, state type and the masked compare shared by the CAN
  acceptance, bit timing and fault confinement block.
  assumes nothing of its surroundings.
*/
package cmtf_pkg;

  // ***********************************************************
  // sizes and positions
  // ***********************************************************
  localparam int NUM_BUF = 16;
  // key = {extended flag, 29 identifier bits}
  localparam int KEY_W = 30;
  localparam int SHARED_LAST = 13;
  localparam int BUF_OWN_A = 14;
  localparam int BUF_OWN_B = 15;
  localparam int PROP_LSB = 0;
  localparam int PHASE_SEGMENT_ONE_FIELD_LSB = 3;
  localparam int PHASE_SEGMENT_TWO_FIELD_LSB = 0;
  localparam int RJW_LSB = 6;

  // ***********************************************************
  // reset values and limits
  // ***********************************************************
  localparam logic [7:0] TIMING_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [7:0] ERR_STEP = 8'h08;
  localparam logic [7:0] PASSIVE_LIM = 8'h80;
  localparam logic [7:0] RX_RELOAD = 8'h78;
  localparam logic [3:0] RECESSIVE_RUN = 4'hb;
  localparam logic [15:0] MIN_BIT_CLKS = 16'h0009;
  localparam logic [15:0] SOF_SAFE_CLKS = 16'h000a;
  localparam logic [1:0] IPT_FAST = 2'h3;
  localparam logic [1:0] IPT_SLOW = 2'h2;
  localparam logic [2:0] PHASE_SEGMENT_TWO_FIELD_LATE = 3'h2;

  typedef enum logic [2:0] {
    FCS_ACTIVE = 3'b001,
    FCS_PASSIVE = 3'b010,
    FCS_BUSOFF = 3'b100
  } cmtf_fcs_t;

  function automatic logic cmtf_match(
    input logic [KEY_W-1:0] a,
    input logic [KEY_W-1:0] b,
    input logic [KEY_W-1:0] m
  );
    cmtf_match = (((a ^ b) & m) == '0);
  endfunction : cmtf_match

endpackage : cmtf_pkg

// file: tb_top.sv
/*
  self-checking bench of the masking, timing and fault confinement block.
  assumes cmtf_core and the bus node model are compiled before it.
*/
`timescale 1ns/1ps
module tb_top;
  import cmtf_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic soft_reset = 1'b0, cfg_write_ok = 1'b0, cs_read = 1'b0;
  logic timer_read = 1'b0, timer_sync_en = 1'b0, tx_frame_ok = 1'b0;
  logic tx_err = 1'b0, ack_err = 1'b0, rx_err_one = 1'b0;
  logic rx_err_eight = 1'b0, bits_go = 1'b0, frame_go = 1'b0;
  logic [2:0] timing_we = 3'h0;
  logic [7:0] timing_wdata = 8'h00, cnt_wdata = 8'h00;
  logic [1:0] cnt_we = 2'h0;
  logic [3:0] cs_read_idx = 4'h0;
  logic [KEY_W-1:0] mask_shared = '0, mask_own_a = '0, mask_own_b = '0;
  logic [KEY_W-1:0] frame_key = '0, rx_key, base;
  logic [NUM_BUF*KEY_W-1:0] buf_key = '0;
  logic [15:0] buf_rx_active = 16'h0000, bits_n = 16'h0000;
  logic [15:0] dom_at = 16'hffff;
  logic bit_tick, bus_recessive, id_start, rx_frame_ok, busy;
  cmtf_fcs_t fault_confinement_state;
  logic [7:0] tx_err_cnt_q, rx_err_cnt_q, quantum_prescaler_divider;
  logic [7:0] bit_timing_control_one, bit_timing_control_two;
  logic busoff_evt_q, err_flag_passive_q, tx_delay_q, bus_drive_en_q;
  logic quantum_tick_q, tx_late_q, cfg_phase_segment_two_field_bad_q, cfg_bit_short_q;
  logic sof_risk_q, dlv_q, lock_valid_q, tx_stamp_vld_q;
  logic [1:0] info_processing_time;
  logic [3:0] dlv_idx_q, lock_idx_q;
  logic [15:0] dlv_stamp_q, timer_q, tx_stamp_q, last_stamp;
  logic [15:0] lfsr_q = 16'h0022;
  logic [3:0] exp_q[$];
  int num_errors = 0;
  int checks = 0;
  int n;

  cmtf_core cmtf_core_inst (.*);
  cmtf_bus_node cmtf_bus_node_inst (.*);

  always #12.5 mclk = ~mclk;

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic end_of_test();
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask : cyc

  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    @(posedge mclk);
    while (busy && k < lim)
    begin
      @(posedge mclk);
      k++;
    end
    if (busy)
    begin
      num_errors++;
      $display("unexpected at %0t: bus model hang", $time);
      end_of_test();
    end
  endtask : wait_idle

  task automatic send_bits(input logic [15:0] k, input logic [15:0] d);
    @(posedge mclk);
    bits_n <= k;
    dom_at <= d;
    bits_go <= 1'b1;
    @(posedge mclk);
    bits_go <= 1'b0;
    wait_idle(20000);
    // last tick is taken as the model goes idle; let the result settle
    cyc(2);
  endtask : send_bits

  task automatic send_frame(input logic [KEY_W-1:0] k, input logic hit,
                            input logic [3:0] idx);
    if (hit)
      exp_q.push_back(idx);
    @(posedge mclk);
    frame_key <= k;
    frame_go <= 1'b1;
    @(posedge mclk);
    frame_go <= 1'b0;
    wait_idle(50);
    cyc(2);
  endtask : send_frame

  task automatic set_timing(input logic [2:0] we, input logic [7:0] d);
    @(posedge mclk);
    timing_we <= we;
    timing_wdata <= d;
    @(posedge mclk);
    timing_we <= 3'h0;
    cyc(3);
  endtask : set_timing

  task automatic set_cnt(input logic [1:0] we, input logic [7:0] d,
                         input logic ok);
    @(posedge mclk);
    cnt_we <= we;
    cnt_wdata <= d;
    cfg_write_ok <= ok;
    @(posedge mclk);
    cnt_we <= 2'h0;
    cfg_write_ok <= 1'b0;
    cyc(1);
  endtask : set_cnt

  // order: soft reset, tx err, rx +1, rx +8, tx ok, timer read
  task automatic pulse(input logic [5:0] p);
    @(posedge mclk);
    {soft_reset, tx_err, rx_err_one, rx_err_eight, tx_frame_ok,
     timer_read} <= p;
    @(posedge mclk);
    {soft_reset, tx_err, rx_err_one, rx_err_eight, tx_frame_ok,
     timer_read} <= 6'h00;
    cyc(1);
  endtask : pulse

  task automatic cs(input logic [3:0] i);
    @(posedge mclk);
    cs_read <= 1'b1;
    cs_read_idx <= i;
    @(posedge mclk);
    cs_read <= 1'b0;
    cyc(1);
  endtask : cs

  // ***********************************************************
  // delivery monitor
  // ***********************************************************
  always @(posedge mclk)
  begin
    if (rstn && dlv_q === 1'b1)
    begin
      last_stamp = dlv_stamp_q;
      if (exp_q.size() == 0)
      begin
        num_errors++;
        $display("unexpected at %0t: delivery not due", $time);
      end
      else
        chk(dlv_idx_q, exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    $display("unexpected at %0t: run too long", $time);
    end_of_test();
  end

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial
  begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    cyc(1);
    chk(fault_confinement_state, FCS_ACTIVE);
    chk({tx_err_cnt_q, rx_err_cnt_q}, 16'h0000);
    chk(info_processing_time, 2'h3);
    set_cnt(2'h3, 8'h40, 1'b0);
    chk({tx_err_cnt_q, rx_err_cnt_q}, 16'h0000);
    set_timing(3'h1, 8'h07);
    chk(quantum_prescaler_divider, 8'h00);
    cfg_write_ok <= 1'b1;
    set_timing(3'h1, 8'h03);
    set_timing(3'h4, 8'h02);
    chk(bit_timing_control_two, 8'h02);
    chk({info_processing_time, tx_late_q}, 3'b101);
    n = 0;
    while (quantum_tick_q !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    n = 1;
    while (quantum_tick_q !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    chk(n, 32'd4);
    set_timing(3'h1, 8'h00);
    set_timing(3'h2, 8'h05);
    set_timing(3'h4, 8'h00);
    chk({cfg_bit_short_q, sof_risk_q, cfg_phase_segment_two_field_bad_q}, 3'b011);
    set_timing(3'h2, 8'h04);
    chk(cfg_bit_short_q, 1'b1);
    set_timing(3'h1, 8'h03);
    chk({sof_risk_q, info_processing_time}, 3'b010);
    cfg_write_ok <= 1'b0;
    lfsr_q = lfsr(lfsr_q);
    base[15:0] = lfsr_q;
    lfsr_q = lfsr(lfsr_q);
    base[29:16] = {1'b0, lfsr_q[12:0]};
    buf_key[0 +: KEY_W] <= base ^ 30'h1000_0000;
    buf_key[2*KEY_W +: KEY_W] <= base;
    buf_key[3*KEY_W +: KEY_W] <= base | 30'h2000_0000;
    buf_key[5*KEY_W +: KEY_W] <= base;
    buf_key[14*KEY_W +: KEY_W] <= base ^ 30'h0000_ff00;
    buf_key[15*KEY_W +: KEY_W] <= base ^ 30'h00ff_0000;
    buf_rx_active <= 16'hc02d;
    mask_shared <= 30'h3fff_fff0;
    mask_own_a <= 30'h3fff_fff0;
    mask_own_b <= 30'h3f00_ffff;
    send_frame(base ^ 30'h0000_0005, 1'b1, 4'h2);
    send_frame(base | 30'h2000_0000, 1'b1, 4'h3);
    send_frame(base ^ 30'h0000_0010, 1'b0, 4'h0);
    send_frame(base ^ 30'h0000_ff01, 1'b1, 4'he);
    send_frame(base ^ 30'h0055_0000, 1'b1, 4'hf);
    timer_sync_en <= 1'b1;
    send_frame(base ^ 30'h1000_0003, 1'b1, 4'h0);
    chk(timer_q < 16'h0008, 1'b1);
    timer_sync_en <= 1'b0;
    pulse(6'h02);
    chk({tx_stamp_vld_q, tx_stamp_q}, {1'b1, last_stamp});
    cs(4'h3);
    cs(4'h2);
    chk({lock_valid_q, lock_idx_q}, 5'h12);
    send_frame(base ^ 30'h0000_0002, 1'b0, 4'h0);
    mask_shared <= 30'h3fff_ffff;
    exp_q.push_back(4'h2);
    pulse(6'h01);
    cyc(2);
    chk({lock_valid_q, exp_q.size()}, 33'h0);
    set_cnt(2'h1, 8'h7f, 1'b1);
    pulse(6'h10);
    cyc(1);
    chk(tx_err_cnt_q, 8'h87);
    chk({fault_confinement_state, err_flag_passive_q, tx_delay_q},
        {FCS_PASSIVE, 2'b11});
    set_cnt(2'h1, 8'hfa, 1'b1);
    ack_err <= 1'b1;
    pulse(6'h10);
    ack_err <= 1'b0;
    chk({fault_confinement_state, tx_err_cnt_q}, {FCS_PASSIVE, 8'hfa});
    set_cnt(2'h2, 8'h50, 1'b1);
    pulse(6'h10);
    chk(busoff_evt_q, 1'b1);
    chk({fault_confinement_state, tx_err_cnt_q}, {FCS_BUSOFF, 8'h00});
    cyc(1);
    chk(bus_drive_en_q, 1'b0);
    send_bits(16'd22, 16'd10);
    chk(tx_err_cnt_q, 8'h01);
    send_bits(16'd1397, 16'hffff);
    chk({fault_confinement_state, tx_err_cnt_q, rx_err_cnt_q},
        {FCS_ACTIVE, 16'h0000});
    chk(bus_drive_en_q, 1'b1);
    set_cnt(2'h2, 8'h7c, 1'b1);
    pulse(6'h04);
    pulse(6'h08);
    cyc(1);
    chk({fault_confinement_state, rx_err_cnt_q}, {FCS_PASSIVE, 8'h84});
    send_frame(base, 1'b1, 4'h2);
    cyc(1);
    chk(rx_err_cnt_q >= 8'h77 && rx_err_cnt_q <= 8'h7f, 1'b1);
    chk(fault_confinement_state, FCS_ACTIVE);
    set_cnt(2'h3, 8'h90, 1'b1);
    pulse(6'h20);
    chk({tx_err_cnt_q, rx_err_cnt_q}, 16'h0000);
    chk(exp_q.size(), 32'd0);
    end_of_test();
  end
endmodule : tb_top
